// ===== verilog/tat_pkg.sv
// package: register map, field positions, reset values and types of the 16-bit timer
package tat_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [11:0] TAT_CONTROL_OFF = 12'h600;
    localparam logic [11:0] TAT_COUNT_OFF = 12'h610;
    localparam logic [11:0] TAT_PERIOD_OFF = 12'h620;
    localparam logic [11:0] TAT_IRQ_STAT_OFF = 12'h630;
    localparam logic [11:0] TAT_IRQ_CLR_OFF = 12'h640;
    localparam logic [11:0] TAT_IRQ_EN_OFF = 12'h650;
    localparam logic [3:0] TAT_ALIAS_CLR = 4'h4;
    localparam logic [3:0] TAT_ALIAS_SET = 4'h8;
    localparam logic [3:0] TAT_ALIAS_INV = 4'hC;

    // ****************************************
    // control word fields
    // ****************************************
    localparam int TAT_ON_BIT = 15;
    localparam int TAT_STOP_IN_IDLE_BIT = 13;
    localparam int TAT_WBLK_BIT = 12;
    localparam int TAT_WPEND_BIT = 11;
    localparam int TAT_GATE_BIT = 7;
    localparam int TAT_PS_LSB = 4;
    localparam int TAT_SYNC_BIT = 2;
    localparam int TAT_CS_BIT = 1;
    localparam logic [15:0] TAT_CONTROL_WMASK = 16'hB0B6;

    // ****************************************
    // reset values and prescale counts
    // ****************************************
    localparam logic [15:0] TAT_CONTROL_RST = 16'h0000;
    localparam logic [15:0] TAT_COUNT_RST = 16'h0000;
    localparam logic [15:0] TAT_PERIOD_RST = 16'hFFFF;
    localparam logic [7:0] TAT_PS_DIV1 = 8'h00;
    localparam logic [7:0] TAT_PS_DIV8 = 8'h07;
    localparam logic [7:0] TAT_PS_DIV64 = 8'h3F;
    localparam logic [7:0] TAT_PS_DIV256 = 8'hFF;

    // interrupt status bits
    localparam int TAT_EV_PERIOD = 0;
    localparam int TAT_EV_GATE = 1;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tat_bus_req_type;

    typedef enum logic [1:0] {
        TAT_OP_WRITE,
        TAT_OP_CLR,
        TAT_OP_SET,
        TAT_OP_INV
    } tat_op_type;

endpackage

// ===== verilog/tat_sync2.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module tat_sync2 (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta_reg <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/tat_prescale.sv
// prescaler: passes one tick out of 1, 8, 64 or 256 input ticks
`timescale 1ns/1ps
`default_nettype none
module tat_prescale
    import tat_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic clear_i,
    input wire logic tick_i,
    input wire logic [1:0] sel_i,
    output logic tick_o
);
    logic [7:0] cnt_reg;
    logic [7:0] limit;

    always_comb begin
        case (sel_i)
            2'h0: limit = TAT_PS_DIV1;
            2'h1: limit = TAT_PS_DIV8;
            2'h2: limit = TAT_PS_DIV64;
            default: limit = TAT_PS_DIV256;
        endcase
    end

    assign tick_o = tick_i && (cnt_reg >= limit);

    always_ff @(posedge clk_i) begin
        if (!rst_b_i || clear_i) begin
            cnt_reg <= 8'h00;
        end else if (tick_i) begin
            cnt_reg <= (cnt_reg >= limit) ? 8'h00 : cnt_reg + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/tat_timer.sv
// 16-bit type A timer: registers, clock selection, gating, count and interrupt
`timescale 1ns/1ps
`default_nettype none

//Contract
// - the timer counts only while control bit 15 is one and stops when it is cleared.
// - with bit 13 set the timer halts while the device is idle, otherwise it runs on.
// - with bit 12 set, count writes are ignored while an earlier async write is pending.
// - with bit 12 clear, back-to-back count writes are all accepted.
// - in async mode bit 11 reads one while a count write is still crossing over.
// - in sync mode bit 11 always reads zero.
// - gate enable bit 7 acts only with the internal clock and is ignored otherwise.
// - bits 5-4 divide the counting clock by 1, 8, 64 or 256.
// - with the external clock, bit 2 selects synchronised or unsynchronised input; when clear the synchronised pin is still used, one cycle later.
// - bit 1 selects the external clock pin when set and the internal clock when clear.
// - bits 31-16 and all unassigned control bits read as zero.
// - the control, count, period and interrupt enable registers have clear, set and invert aliases at offsets 0x4, 0x8 and 0xC.
// - the timer keeps running through idle when so configured.
module tat_timer
    import tat_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic idle_i,
    input wire logic ext_timer_clock_pin_i,
    input wire logic gate_i,
    output logic [31:0] rdata_o,
    output logic irq_o
);
    // ****************************************
    // registers and signals
    // ****************************************
    tat_bus_req_type req;
    logic [15:0] control_word_reg;
    logic [15:0] count_value_reg;
    logic [15:0] period_value_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_en_reg;
    logic [15:0] pend_data_reg;
    logic pend_tgl_reg;
    logic ack_tgl_reg;
    logic [1:0] ack_sync_reg;
    logic ext_sync;
    logic ext_raw_reg;
    logic ext_prev_reg;
    logic gate_sync;
    logic gate_prev_reg;
    logic [11:0] base;
    tat_op_type op;
    logic [15:0] wval;
    logic [15:0] control_word_next;
    logic [15:0] count_value_next;
    logic [15:0] period_value_next;
    logic [15:0] irq_en_next;
    logic on_bit, stop_in_idle_bit, wblk_bit, gate_bit, sync_bit, cs_bit;
    logic async_mode;
    logic async_write_pending;
    logic count_wr;
    logic run;
    logic ext_edge;
    logic raw_tick;
    logic ps_tick;
    logic gated;
    logic gate_fall;
    logic period_hit;
    logic [1:0] ev;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign on_bit = control_word_reg[TAT_ON_BIT];
    assign stop_in_idle_bit = control_word_reg[TAT_STOP_IN_IDLE_BIT];
    assign wblk_bit = control_word_reg[TAT_WBLK_BIT];
    assign gate_bit = control_word_reg[TAT_GATE_BIT];
    assign sync_bit = control_word_reg[TAT_SYNC_BIT];
    assign cs_bit = control_word_reg[TAT_CS_BIT];
    assign async_mode = cs_bit && !sync_bit;

    // ****************************************
    // address decode and alias operation
    // ****************************************
    always_comb begin
        base = {req.addr[11:4], 4'h0};
        case (req.addr[3:0])
            TAT_ALIAS_CLR: op = TAT_OP_CLR;
            TAT_ALIAS_SET: op = TAT_OP_SET;
            TAT_ALIAS_INV: op = TAT_OP_INV;
            default: op = TAT_OP_WRITE;
        endcase
    end

    // alias operation applied to a current value
    function automatic logic [15:0] apply_op(input tat_op_type o, input logic [15:0] cur,
                                             input logic [15:0] d);
        case (o)
            TAT_OP_CLR: apply_op = cur & ~d;
            TAT_OP_SET: apply_op = cur | d;
            TAT_OP_INV: apply_op = cur ^ d;
            default: apply_op = d;
        endcase
    endfunction

    assign wval = req.wdata[15:0];
    assign control_word_next = apply_op(op, control_word_reg, wval) & TAT_CONTROL_WMASK;
    assign count_value_next = apply_op(op, count_value_reg, wval);
    assign period_value_next = apply_op(op, period_value_reg, wval);
    assign irq_en_next = apply_op(op, {14'h0000, irq_en_reg}, wval);

    // ****************************************
    // control and period registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            control_word_reg <= TAT_CONTROL_RST;
        end else if (req.wr && base == TAT_CONTROL_OFF) begin
            control_word_reg <= control_word_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            period_value_reg <= TAT_PERIOD_RST;
        end else if (req.wr && base == TAT_PERIOD_OFF) begin
            period_value_reg <= period_value_next;
        end
    end

    // ****************************************
    // asynchronous count write handshake
    // ****************************************
    // write is held until the next external edge takes it over
    assign async_write_pending = async_mode && (pend_tgl_reg != ack_sync_reg[1]);
    assign count_wr = req.wr && base == TAT_COUNT_OFF
        && !(wblk_bit && async_write_pending);

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pend_tgl_reg <= 1'b0;
            pend_data_reg <= TAT_COUNT_RST;
        end else if (count_wr && async_mode) begin
            pend_data_reg <= count_value_next;
            if (!async_write_pending) begin
                pend_tgl_reg <= ~pend_tgl_reg;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ack_sync_reg <= 2'b00;
        end else begin
            ack_sync_reg <= {ack_sync_reg[0], ack_tgl_reg};
        end
    end

    // ****************************************
    // clock source and gate
    // ****************************************
    tat_sync2 u_ext_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(ext_timer_clock_pin_i),
        .q_o(ext_sync)
    );

    tat_sync2 u_gate_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(gate_i),
        .q_o(gate_sync)
    );

    // unsynchronised path adds one more register stage after the two-stage synchroniser
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ext_raw_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
            gate_prev_reg <= 1'b0;
        end else begin
            ext_raw_reg <= ext_sync;
            ext_prev_reg <= sync_bit ? ext_sync : ext_raw_reg;
            gate_prev_reg <= gate_sync;
        end
    end

    assign ext_edge = (sync_bit ? ext_sync : ext_raw_reg) && !ext_prev_reg;
    assign run = on_bit && !(stop_in_idle_bit && idle_i);
    assign gated = !cs_bit && gate_bit;
    assign raw_tick = run && (cs_bit ? ext_edge : (!gated || gate_sync));
    assign gate_fall = run && gated && gate_prev_reg && !gate_sync;

    tat_prescale u_prescale (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .clear_i(!on_bit),
        .tick_i(raw_tick),
        .sel_i(control_word_reg[TAT_PS_LSB +: 2]),
        .tick_o(ps_tick)
    );

    // ****************************************
    // counter
    // ****************************************
    assign period_hit = ps_tick && count_value_reg == period_value_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            count_value_reg <= TAT_COUNT_RST;
            ack_tgl_reg <= 1'b0;
        end else if (count_wr && !async_mode) begin
            count_value_reg <= count_value_next;
        end else if (async_mode && ext_edge && pend_tgl_reg != ack_tgl_reg) begin
            count_value_reg <= pend_data_reg;
            ack_tgl_reg <= pend_tgl_reg;
        end else if (period_hit) begin
            count_value_reg <= 16'h0000;
        end else if (ps_tick) begin
            count_value_reg <= count_value_reg + 16'h0001;
        end
    end

    // ****************************************
    // interrupt status, enable, clear
    // ****************************************
    assign ev = {gate_fall, period_hit};

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_stat_reg <= 2'b00;
        end else if (req.wr && base == TAT_IRQ_CLR_OFF) begin
            irq_stat_reg <= (irq_stat_reg & ~req.wdata[1:0]) | ev;
        end else begin
            irq_stat_reg <= irq_stat_reg | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_en_reg <= 2'b00;
        end else if (req.wr && base == TAT_IRQ_EN_OFF) begin
            irq_en_reg <= irq_en_next[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |((irq_stat_reg | ev) & irq_en_reg);
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (req.rd) begin
            case (base)
                TAT_CONTROL_OFF: rdata_o <= {16'h0000, control_word_reg
                    | (16'(async_write_pending) << TAT_WPEND_BIT)};
                TAT_COUNT_OFF: rdata_o <= {16'h0000, count_value_reg};
                TAT_PERIOD_OFF: rdata_o <= {16'h0000, period_value_reg};
                TAT_IRQ_STAT_OFF: rdata_o <= {30'h0000_0000, irq_stat_reg};
                TAT_IRQ_EN_OFF: rdata_o <= {30'h0000_0000, irq_en_reg};
                default: rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_off_no_count: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !on_bit && !(count_wr || $past(count_wr)) |=> $stable(count_value_reg))
        else $error("count moved while disabled");
    a_idle_halt: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        stop_in_idle_bit && idle_i |-> !raw_tick)
        else $error("tick while stopped in idle");
    a_sync_no_pend: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !async_mode |-> !async_write_pending)
        else $error("write pending in sync mode");
    a_blocked_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        req.wr && base == TAT_COUNT_OFF && wblk_bit && async_write_pending
        |=> $stable(pend_data_reg))
        else $error("blocked count write accepted");
    a_gate_ignored: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cs_bit |-> !gate_fall)
        else $error("gate acted with external clock");
    a_period_wrap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        period_hit && !count_wr && !async_mode |=> count_value_reg == 16'h0000
        && irq_stat_reg[TAT_EV_PERIOD])
        else $error("no wrap at period");
    a_gate_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        gate_fall |=> irq_stat_reg[TAT_EV_GATE])
        else $error("gate fall not flagged");
    a_ctl_zeros: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $past(req.rd) && $past(base) == TAT_CONTROL_OFF |-> rdata_o[31:16] == 16'h0000
        && rdata_o[14] == 1'b0 && rdata_o[10:8] == 3'h0)
        else $error("unimplemented control bits nonzero");
    a_alias_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        req.wr && req.addr == (TAT_PERIOD_OFF | 12'(TAT_ALIAS_SET))
        |=> period_value_reg == ($past(period_value_reg) | $past(wval)))
        else $error("set alias failed");
endmodule
`default_nettype wire

// ===== test/tat_timer_tb.sv
// self-checking bench for the 16-bit timer
`timescale 1ns/1ps
`default_nettype none
module tat_timer_tb import tat_pkg::*; ;
    // ****************************************
    // stimulus and wiring
    // ****************************************
    localparam logic [31:0] c_on = 32'h1 << TAT_ON_BIT;
    localparam logic [31:0] c_stop_in_idle = 32'h1 << TAT_STOP_IN_IDLE_BIT;
    localparam logic [31:0] c_wblk = 32'h1 << TAT_WBLK_BIT;
    localparam logic [31:0] c_wpend = 32'h1 << TAT_WPEND_BIT;
    localparam logic [31:0] c_gate = 32'h1 << TAT_GATE_BIT;
    localparam logic [31:0] c_sync = 32'h1 << TAT_SYNC_BIT;
    localparam logic [31:0] c_cs = 32'h1 << TAT_CS_BIT;
    localparam logic [11:0] a_ctl = TAT_CONTROL_OFF;
    localparam logic [11:0] a_cnt = TAT_COUNT_OFF;
    localparam logic [11:0] a_per = TAT_PERIOD_OFF;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic idle = 1'b0;
    logic pin = 1'b0;
    logic gate = 1'b0;
    logic [31:0] rdata;
    logic irq;
    logic [31:0] v;
    logic [31:0] v0;
    int err_count = 0;
    int compares = 0;
    int div [4] = '{1, 8, 64, 256};

    always #50 clk = ~clk;

    tat_timer dut_u (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .idle_i(idle), .ext_timer_clock_pin_i(pin), .gate_i(gate), .rdata_o(rdata),
        .irq_o(irq));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic inr(input string name, input logic [31:0] seen, input int lo, input int hi);
        chk(name, {31'h0, (seen >= lo && seen <= hi)}, 32'h1);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // every access leaves one quiet cycle behind it
    task automatic bw(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic br(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk);
            pin <= 1'b1;
            cyc(4);
            pin <= 1'b0;
            cyc(4);
        end
    endtask

    task automatic results();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        br(a_ctl, v);
        chk("control reset", v, {16'h0, TAT_CONTROL_RST});
        br(a_cnt, v);
        chk("count reset", v, {16'h0, TAT_COUNT_RST});
        br(a_per, v);
        chk("period reset", v, {16'h0, TAT_PERIOD_RST});
        br(TAT_IRQ_STAT_OFF, v);
        chk("status reset", v, 32'h0);
        br(12'h7F0, v);
        chk("unmapped read", v, 32'h0);
    endtask

    task automatic t_alias();
        bw(a_ctl, 32'hFFFF_FFFF);
        br(a_ctl, v);
        chk("control mask", v, {16'h0, TAT_CONTROL_WMASK});
        bw(a_ctl | 12'(TAT_ALIAS_CLR), 32'hFFFF);
        br(a_ctl, v);
        chk("control clr", v, 32'h0);
        bw(a_ctl | 12'(TAT_ALIAS_SET), 32'h30);
        br(a_ctl, v);
        chk("control set", v, 32'h30);
        bw(a_ctl | 12'(TAT_ALIAS_INV), 32'h20);
        br(a_ctl, v);
        chk("control inv", v, 32'h10);
        bw(a_per | 12'(TAT_ALIAS_INV), 32'h00FF);
        br(a_per, v);
        chk("period inv", v, 32'hFF00);
        bw(a_ctl, 32'h0);
    endtask

    task automatic t_period();
        bw(a_per, 32'h9);
        bw(a_cnt, 32'h0);
        bw(TAT_IRQ_EN_OFF, 32'h1);
        bw(a_ctl, c_on);
        cyc(30);
        bw(a_ctl, 32'h0);
        br(a_cnt, v);
        inr("count wrapped", v, 0, 9);
        br(TAT_IRQ_STAT_OFF, v);
        chk("status period", v, 32'h1);
        chk("irq raised", {31'h0, irq}, 32'h1);
        bw(TAT_IRQ_EN_OFF, 32'h0);
        cyc(2);
        chk("irq masked", {31'h0, irq}, 32'h0);
        bw(TAT_IRQ_EN_OFF | 12'(TAT_ALIAS_SET), 32'h1);
        cyc(2);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        bw(TAT_IRQ_CLR_OFF, 32'h3);
        br(TAT_IRQ_STAT_OFF, v);
        chk("status cleared", v, 32'h0);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        bw(a_per, 32'hFFFF);
    endtask

    task automatic t_prescale();
        for (int s = 0; s < 4; s++) begin
            bw(a_cnt, 32'h0);
            bw(a_ctl, c_on | (32'(s) << TAT_PS_LSB));
            cyc(20 * div[s]);
            bw(a_ctl, 32'h0);
            br(a_cnt, v0);
            inr("prescaled count", v0, 19, 24);
            cyc(10);
            br(a_cnt, v);
            chk("stopped count", v, v0);
        end
    endtask

    task automatic t_idle();
        @(posedge clk);
        idle <= 1'b1;
        bw(a_cnt, 32'h0);
        bw(a_ctl, c_on | c_stop_in_idle);
        cyc(20);
        br(a_cnt, v);
        chk("halted in idle", v, 32'h0);
        idle <= 1'b0;
        cyc(20);
        br(a_cnt, v);
        inr("runs out of idle", v, 15, 40);
        bw(a_ctl, c_on);
        idle <= 1'b1;
        br(a_cnt, v0);
        cyc(20);
        br(a_cnt, v);
        inr("runs through idle", v, int'(v0) + 15, int'(v0) + 30);
        idle <= 1'b0;
        bw(a_ctl, 32'h0);
    endtask

    task automatic t_gate();
        bw(a_cnt, 32'h0);
        bw(TAT_IRQ_CLR_OFF, 32'h3);
        bw(a_ctl, c_on | c_gate);
        cyc(20);
        br(a_cnt, v);
        chk("gate low holds", v, 32'h0);
        @(posedge clk);
        gate <= 1'b1;
        cyc(30);
        gate <= 1'b0;
        cyc(10);
        bw(a_ctl, 32'h0);
        br(a_cnt, v);
        inr("gated count", v, 25, 35);
        br(TAT_IRQ_STAT_OFF, v);
        chk("gate fall event", v, 32'h2);
        bw(TAT_IRQ_CLR_OFF, 32'h3);
    endtask

    task automatic t_ext();
        bw(a_cnt, 32'h0);
        bw(a_ctl, c_on | c_cs | c_sync | c_gate);
        cyc(20);
        br(a_cnt, v);
        chk("ext ignores clock", v, 32'h0);
        pulse(5);
        cyc(6);
        br(a_cnt, v);
        chk("ext synced edges", v, 32'h5);
        bw(a_ctl, c_on | c_cs);
        pulse(3);
        cyc(6);
        br(a_cnt, v);
        chk("ext unsynced edges", v, 32'h8);
        bw(a_ctl, 32'h0);
    endtask

    task automatic t_async();
        bw(a_ctl, c_on | c_cs | c_wblk);
        bw(a_cnt, 32'h1234);
        br(a_ctl, v);
        chk("write pending", v & c_wpend, c_wpend);
        bw(a_cnt, 32'h5678);
        pulse(1);
        cyc(6);
        br(a_ctl, v);
        chk("write done", v & c_wpend, 32'h0);
        br(a_cnt, v);
        inr("blocked write", v, 32'h1234, 32'h1235);
        bw(a_ctl, c_on | c_cs);
        @(posedge clk);
        addr <= a_cnt;
        wdata <= 32'h1111;
        wr <= 1'b1;
        @(posedge clk);
        wdata <= 32'h2222;
        @(posedge clk);
        wr <= 1'b0;
        pulse(1);
        cyc(6);
        br(a_cnt, v);
        inr("back to back", v, 32'h2222, 32'h2223);
        bw(a_cnt, 32'h10);
        bw(a_ctl, c_on);
        br(a_ctl, v);
        chk("sync no pending", v, c_on);
        bw(a_ctl, 32'h0);
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_alias();
        t_period();
        t_prescale();
        t_idle();
        t_gate();
        t_ext();
        t_async();
        results();
    end

    initial begin
        #2000000;
        err_count++;
        results();
    end
endmodule
`default_nettype wire
